//--- rtl/fcc_ctrl.sv
// fast-charge control: conditions, register file, charger state machine
`timescale 1ns/1ps
module fcc_ctrl
    import fcc_pkg::*;
#(
    parameter int HOT_HOLD_CYC = fcc_pkg::HOT_CYC,     // least pause length
    parameter int STEP3_CYC    = fcc_pkg::STEP_T3_CYC  // longest step interval
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    input  wire logic [7:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [15:0]     reg_rdata,
    input  wire logic       sys_active,
    input  wire logic       src_wall_sel,
    input  wire logic       usb_high_power,
    input  wire logic       src_volt_ok,
    input  wire logic       batt_above_min,
    input  wire logic       batt_low_det,
    input  wire logic       die_over_temp,
    input  wire logic       usb_ilim_hit,
    input  wire logic       key_unlocked,
    output logic            fast_active,
    output logic            charge_paused,
    output logic            charge_stopped,
    output logic            trickle_select,
    output logic            eoc_suppress,
    output logic [3:0]      fast_current,
    output logic            timer_reload
);
    import fcc_pkg::*;

    fcc_step_if sif ();              // stepper link
    fcc_state_type st_r;             // charger state
    fcc_state_type st_nxt;           // next charger state
    logic              cond_r;       // fast conditions met, registered
    logic              cond_q;       // previous conditions value
    logic              cond_rise;    // conditions just became true
    logic              ready_r;      // ready seen since conditions rose
    logic              ready_evt_r;  // sticky ready event flag
    logic              en_r;         // fast charge enable
    logic              en_nxt;       // next enable value
    logic              thr_r;        // usb throttle enable
    logic [3:0]        isel_r;       // fast current limit
    logic [1:0]        step_r;       // throttle step time
    logic [HOT_W-1:0]  hot_cnt_r;    // pause length counter
    logic              hot_done;     // least pause elapsed
    logic [1:0]        sts_code;     // state code for readback
    logic              wr_ok;        // keyed write
    logic              rd_isr;       // read of interrupt status

    // a locked key drops a keyed write silently, no error is flagged
    assign cond_rise = cond_r && !cond_q;
    assign wr_ok     = reg_wr && key_unlocked;
    assign rd_isr    = reg_rd && reg_addr == ADR_INT_STAT_ONE;
    assign hot_done  = hot_cnt_r >= HOT_W'(HOT_HOLD_CYC - 1);

    // gather and register the fast charge conditions
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cond_r <= 1'b0;
            cond_q <= 1'b0;
        end else begin
            cond_r <= sys_active && (src_wall_sel || usb_high_power)
                      && src_volt_ok && batt_above_min && !batt_low_det;
            cond_q <= cond_r;
        end
    end

    // ready level: seen a rising edge and conditions still hold
    // the level, not the read-clear flag, gates the enable write
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ready_r <= 1'b0;
        end else if (!cond_r) begin
            ready_r <= 1'b0;
        end else if (cond_rise) begin
            ready_r <= 1'b1;
        end
    end

    // sticky ready event: a new rise wins over the read clear
    // so a rise in the cycle of a read is never lost
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ready_evt_r <= 1'b0;
        end else if (cond_rise) begin
            ready_evt_r <= 1'b1;
        end else if (rd_isr) begin
            ready_evt_r <= 1'b0;
        end
    end

    // enable next value: held low without conditions, set only after ready
    // a write of 0 always lands; a write of 1 needs the ready level
    always_comb begin
        en_nxt = en_r;
        if (!cond_r) begin
            en_nxt = 1'b0;
        end else if (wr_ok && reg_addr == ADR_CHG_CTRL_ONE) begin
            if (!reg_wdata[BIT_FAST_EN]) begin
                en_nxt = 1'b0;
            end else if (ready_r) begin
                en_nxt = 1'b1;
            end
        end
    end

    // enable register and timer reload on each change
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            en_r         <= 1'b0;
            timer_reload <= 1'b0;
        end else begin
            en_r         <= en_nxt;
            timer_reload <= en_nxt != en_r;
        end
    end

    // keyed control fields
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            thr_r  <= 1'b0;
            isel_r <= ISEL_RST;
            step_r <= STEP_RST;
        end else if (wr_ok) begin
            if (reg_addr == ADR_CHG_CTRL_ONE) begin
                thr_r <= reg_wdata[BIT_THR_EN];
            end else if (reg_addr == ADR_CHG_CTRL_TWO) begin
                isel_r <= reg_wdata[ISEL_LSB +: 4];
            end else if (reg_addr == ADR_CHG_CTRL_THR) begin
                step_r <= reg_wdata[STEP_LSB +: 2];
            end
        end
    end

    // charger state transitions
    // stop is left only by clearing the enable, never on its own
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: begin
                if (en_r && cond_r) begin
                    st_nxt = ST_FAST;
                end
            end
            ST_FAST: begin
                if (!en_r || !cond_r) begin
                    st_nxt = ST_IDLE;
                end else if (die_over_temp) begin
                    st_nxt = ST_HOT;
                end else if (usb_ilim_hit && !thr_r) begin
                    st_nxt = ST_STOP;
                end
            end
            ST_HOT: begin
                if (!en_r || !cond_r) begin
                    st_nxt = ST_IDLE;
                end else if (hot_done && !die_over_temp) begin
                    st_nxt = ST_FAST;
                end
            end
            ST_STOP: begin
                if (!en_r) begin
                    st_nxt = ST_IDLE;
                end
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // pause counter runs only while paused for temperature
    // it halts at its end value so a long pause cannot wrap it
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            hot_cnt_r <= '0;
        end else if (st_r != ST_HOT) begin
            hot_cnt_r <= '0;
        end else if (!hot_done) begin
            hot_cnt_r <= hot_cnt_r + 1'b1;
        end
    end

    // stepper drive: only fast mode uses limit and throttle
    // the stepper restarts from the limit whenever fast charging resumes
    assign sif.run      = st_r == ST_FAST;
    assign sif.thr_en   = thr_r;
    assign sif.ilim_hit = usb_ilim_hit;
    assign sif.step_sel = step_r;
    assign sif.limit    = isel_r;

    fcc_stepper #(
        .STEP3_CYC (STEP3_CYC)
    ) u_step (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .sif     (sif)
    );

    // state code: fast, trickle, or off after termination
    // a pause keeps the fast code: the mode holds, only the current drops
    always_comb begin
        if (st_r == ST_FAST || st_r == ST_HOT) begin
            sts_code = STS_FAST;
        end else if (st_r == ST_STOP) begin
            sts_code = STS_OFF;
        end else begin
            sts_code = STS_TRICKLE;
        end
    end

    // registered charger outputs
    // every pin comes from a flop so no decode glitch reaches the analogue side
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            fast_active    <= 1'b0;
            charge_paused  <= 1'b0;
            charge_stopped <= 1'b0;
            trickle_select <= 1'b1;
            eoc_suppress   <= 1'b0;
            fast_current   <= '0;
        end else begin
            fast_active    <= st_r == ST_FAST;
            charge_paused  <= st_r == ST_HOT;
            charge_stopped <= st_r == ST_STOP;
            trickle_select <= st_r == ST_IDLE;
            eoc_suppress   <= st_r == ST_FAST && thr_r;
            fast_current   <= (st_r == ST_FAST) ? sif.cur : 4'h0;
        end
    end

    // register read, data valid one cycle after the strobe
    // the strobe gate keeps the bus at zero between reads
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= '0;
        end else if (!reg_rd) begin
            reg_rdata <= '0;
        end else if (reg_addr == ADR_INT_STAT_ONE) begin
            reg_rdata <= 16'(ready_evt_r) << BIT_FAST_READY;
        end else if (reg_addr == ADR_CHG_CTRL_ONE) begin
            reg_rdata <= (16'(en_r) << BIT_FAST_EN) | (16'(thr_r) << BIT_THR_EN);
        end else if (reg_addr == ADR_CHG_CTRL_TWO) begin
            reg_rdata <= (16'(sts_code) << STS_LSB) | (16'(isel_r) << ISEL_LSB);
        end else if (reg_addr == ADR_CHG_CTRL_THR) begin
            reg_rdata <= 16'(step_r) << STEP_LSB;
        end else begin
            reg_rdata <= '0;  // unmapped reads zero
        end
    end

    // checks on the guarded behaviour
    a_ready_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
        cond_rise |=> ready_evt_r)
        else $error("ready event not set on conditions rise");
    a_ready_clr: assert property (@(posedge clk_sys) disable iff (!rst_b)
        rd_isr && !cond_rise |=> !ready_evt_r)
        else $error("ready event not cleared by read");
    a_enable_held: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !cond_r |=> !en_r)
        else $error("enable not held low without conditions");
    a_no_auto: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_r == ST_IDLE ##1 st_r == ST_FAST |-> $past(en_r) && $past(cond_r))
        else $error("fast charge began without request");
    a_fast_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !en_r |=> st_r == ST_IDLE || st_r == ST_STOP ##1 !fast_active)
        else $error("fast charge with enable low");
    a_hot_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_r == ST_HOT && !hot_done |=> st_r != ST_FAST)
        else $error("pause ended before least time");
    a_hot_enter: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_r == ST_FAST && en_r && cond_r && die_over_temp |=> st_r == ST_HOT)
        else $error("over-temperature did not pause charging");
    a_usb_term: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_r == ST_FAST && en_r && cond_r && !die_over_temp
        && usb_ilim_hit && !thr_r |=> st_r == ST_STOP ##1 charge_stopped)
        else $error("usb limit did not terminate");
    a_fallback: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_r == ST_FAST && !cond_r |=> st_r == ST_IDLE ##1 trickle_select)
        else $error("no fallback to trickle");
    a_cur_limit: assert property (@(posedge clk_sys) disable iff (!rst_b)
        fast_active |-> fast_current <= $past(isel_r, 2))
        else $error("current above programmed limit");
    a_timer_reload: assert property (@(posedge clk_sys) disable iff (!rst_b)
        en_r != $past(en_r) |-> timer_reload)
        else $error("timer not reloaded on enable change");
    a_eoc_hide: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_r == ST_FAST && thr_r |=> eoc_suppress)
        else $error("end of charge not suppressed");

    // further checks on keying, enable gating, applied current and end-of-charge hiding
    a_key_lock: assert property (@(posedge clk_sys) disable iff (!rst_b)
        reg_wr && !key_unlocked |=> $stable(isel_r) && $stable(thr_r) && $stable(step_r))
        else $error("keyed field changed while locked");
    a_ready_gate: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !ready_r && !en_r |=> !en_r)
        else $error("enable set without ready");
    a_thr_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !thr_r |=> sif.cur == $past(isel_r))
        else $error("current moved with throttle off");
    a_pause_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
        charge_paused |-> fast_current == 4'h0)
        else $error("current applied during pause");
    a_cur_idle: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !fast_active |-> fast_current == 4'h0)
        else $error("fast current outside fast mode");
    a_eoc_clear: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !thr_r |=> !eoc_suppress)
        else $error("end of charge hidden without throttle");
endmodule : fcc_ctrl

//--- inc/fcc_pkg.sv
// constants, register map and state codes for the fast-charge control block
package fcc_pkg;
    // clock rate used to turn times into cycle counts
    localparam int CLK_MHZ        = 40;
    localparam int CLK_HZ         = CLK_MHZ * 1000000;
    // register addresses
    localparam logic [7:0] ADR_INT_STAT_ONE  = 8'h15;
    localparam logic [7:0] ADR_CHG_CTRL_ONE  = 8'ha8;
    localparam logic [7:0] ADR_CHG_CTRL_TWO  = 8'ha9;
    localparam logic [7:0] ADR_CHG_CTRL_THR  = 8'haa;
    // field positions
    localparam int BIT_FAST_READY = 9;
    localparam int BIT_FAST_EN    = 5;
    localparam int BIT_THR_EN     = 4;
    localparam int ISEL_LSB       = 0;
    localparam int STS_LSB        = 12;
    localparam int STEP_LSB       = 5;
    // reset values
    localparam logic [3:0] ISEL_RST = 4'h6;
    localparam logic [1:0] STEP_RST = 2'h0;
    // charger state codes
    localparam logic [1:0] STS_OFF     = 2'h0;
    localparam logic [1:0] STS_TRICKLE = 2'h1;
    localparam logic [1:0] STS_FAST    = 2'h2;
    // throttle step times in microseconds and their cycle counts
    localparam int STEP_T0_US  = 8;
    localparam int STEP_T1_US  = 16;
    localparam int STEP_T2_US  = 32;
    localparam int STEP_T3_US  = 128;
    localparam int STEP_T0_CYC = STEP_T0_US * CLK_MHZ;
    localparam int STEP_T1_CYC = STEP_T1_US * CLK_MHZ;
    localparam int STEP_T2_CYC = STEP_T2_US * CLK_MHZ;
    localparam int STEP_T3_CYC = STEP_T3_US * CLK_MHZ;
    // least over-temperature pause in seconds and cycles
    localparam int HOT_T_S   = 8;
    localparam int HOT_CYC   = HOT_T_S * CLK_HZ;
    localparam int HOT_W     = 29;
    localparam int STEP_W    = 13;
    // one-hot charger states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_FAST = 4'h2,
        ST_HOT  = 4'h4,
        ST_STOP = 4'h8
    } fcc_state_type;
endpackage : fcc_pkg

//--- inc/fcc_step_if.sv
// link between the state machine and the current throttle stepper
`timescale 1ns/1ps
interface fcc_step_if;
    logic       run;      // fast charging in progress
    logic       thr_en;   // usb throttling allowed
    logic       ilim_hit; // usb current limit reached
    logic [1:0] step_sel; // step interval select
    logic [3:0] limit;    // programmed maximum current code
    logic [3:0] cur;      // current code being applied
    modport ctl (output run, thr_en, ilim_hit, step_sel, limit, input cur);
    modport stp (input run, thr_en, ilim_hit, step_sel, limit, output cur);
endinterface : fcc_step_if

//--- rtl/fcc_stepper.sv
// current throttle stepper: walks the charge current down and up in timed steps
`timescale 1ns/1ps
module fcc_stepper
    import fcc_pkg::*;
#(
    parameter int STEP3_CYC = fcc_pkg::STEP_T3_CYC
) (
    input  wire logic clk_sys,
    input  wire logic rst_b,
    fcc_step_if.stp   sif
);
    logic [STEP_W-1:0] cnt_r;   // interval counter
    logic [STEP_W-1:0] ivl;     // interval length for the chosen step time
    logic [3:0]        cur_r;   // current code

    // pick the interval for the selected step time
    always_comb begin
        if (sif.step_sel == 2'h0) begin
            ivl = STEP_W'(STEP_T0_CYC);
        end else if (sif.step_sel == 2'h1) begin
            ivl = STEP_W'(STEP_T1_CYC);
        end else if (sif.step_sel == 2'h2) begin
            ivl = STEP_W'(STEP_T2_CYC);
        end else begin
            ivl = STEP_W'(STEP3_CYC);
        end
    end

    // interval counter, restarts whenever fast charging is not running
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= '0;
        end else if (!sif.run || cnt_r >= ivl - 1'b1) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // current code: never above the limit, stepped only while throttling
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cur_r <= '0;
        end else if (!sif.run || !sif.thr_en || cur_r > sif.limit) begin
            cur_r <= sif.limit;
        end else if (cnt_r >= ivl - 1'b1) begin
            if (sif.ilim_hit && cur_r > 4'h1) begin
                cur_r <= cur_r - 1'b1;
            end else if (!sif.ilim_hit && cur_r < sif.limit) begin
                cur_r <= cur_r + 1'b1;
            end
        end
    end

    assign sif.cur = cur_r;
endmodule : fcc_stepper

//--- tb/fcc_batt_model.sv
// battery and power source model that feeds the charger condition inputs
`timescale 1ns/1ps
module fcc_batt_model #(
    parameter int MIN_MV = 3100, // least battery voltage for fast charging
    parameter int LOW_MV = 3000, // low battery detection level
    parameter int HOT_C  = 115   // die over-temperature threshold
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        set_active,
    input  wire logic        set_wall,
    input  wire logic        set_usb_hi,
    input  wire logic [12:0] batt_mv,
    input  wire logic [7:0]  temp_c,
    input  wire logic [3:0]  usb_cap,
    input  wire logic [3:0]  fast_current,
    output logic             sys_active,
    output logic             src_wall_sel,
    output logic             usb_high_power,
    output logic             src_volt_ok,
    output logic             batt_above_min,
    output logic             batt_low_det,
    output logic             die_over_temp,
    output logic             usb_ilim_hit
);
    // sensors settle one cycle after the analogue world changes
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            {sys_active, src_wall_sel, usb_high_power, src_volt_ok} <= 4'h0;
            {batt_above_min, batt_low_det, die_over_temp, usb_ilim_hit} <= 4'h0;
        end else begin
            sys_active     <= set_active;
            src_wall_sel   <= set_wall;
            usb_high_power <= set_usb_hi;
            src_volt_ok    <= set_wall | set_usb_hi;
            batt_above_min <= (batt_mv > 13'(MIN_MV));
            batt_low_det   <= (batt_mv < 13'(LOW_MV));
            die_over_temp  <= (temp_c > 8'(HOT_C));
            // the usb rail saturates when the drawn code passes its capacity
            usb_ilim_hit   <= !set_wall && set_usb_hi && (fast_current > usb_cap);
        end
    end
endmodule : fcc_batt_model

//--- tb/fcc_ctrl_tb.sv
// self-checking bench for the fast-charge control block
`timescale 1ns/1ps
module fcc_ctrl_tb;
    import fcc_pkg::*;
    logic        clk_sys, rst_b, reg_wr, reg_rd, key_unlocked;
    logic [7:0]  reg_addr, temp_c;
    logic [15:0] reg_wdata, reg_rdata;
    logic        sys_active, src_wall_sel, usb_high_power, src_volt_ok;
    logic        batt_above_min, batt_low_det, die_over_temp, usb_ilim_hit;
    logic        fast_active, charge_paused, charge_stopped, trickle_select;
    logic        eoc_suppress, timer_reload, set_active, set_wall, set_usb_hi;
    logic [3:0]  fast_current, usb_cap, lim;
    logic [12:0] batt_mv;
    int          error_cnt, n_compared, n;
    int          step_exp [4] = '{STEP_T0_CYC, STEP_T1_CYC, STEP_T2_CYC, 20}; // per code

    fcc_ctrl #(.HOT_HOLD_CYC(50), .STEP3_CYC(20)) dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_active(sys_active),
        .src_wall_sel(src_wall_sel), .usb_high_power(usb_high_power),
        .src_volt_ok(src_volt_ok), .batt_above_min(batt_above_min),
        .batt_low_det(batt_low_det), .die_over_temp(die_over_temp),
        .usb_ilim_hit(usb_ilim_hit), .key_unlocked(key_unlocked),
        .fast_active(fast_active), .charge_paused(charge_paused),
        .charge_stopped(charge_stopped), .trickle_select(trickle_select),
        .eoc_suppress(eoc_suppress), .fast_current(fast_current),
        .timer_reload(timer_reload));

    fcc_batt_model batt (
        .clk_sys(clk_sys), .rst_b(rst_b), .set_active(set_active), .set_wall(set_wall),
        .set_usb_hi(set_usb_hi), .batt_mv(batt_mv), .temp_c(temp_c), .usb_cap(usb_cap),
        .fast_current(fast_current), .sys_active(sys_active), .src_wall_sel(src_wall_sel),
        .usb_high_power(usb_high_power), .src_volt_ok(src_volt_ok),
        .batt_above_min(batt_above_min), .batt_low_det(batt_low_det),
        .die_over_temp(die_over_temp), .usb_ilim_hit(usb_ilim_hit));

    // 40 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // compare and count; report a mismatch at once
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one-cycle write strobe
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : wr

    // one-cycle read strobe; data stands only in the following cycle
    task rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    // bounded wait for an output level, then compare it
    task wait_sig(input int s, input logic want);
        logic v;
        v = 1'bx;
        for (int k = 0; k < 40; k++) begin
            @(posedge clk_sys);
            #1;
            case (s)
                0: v = fast_active;
                1: v = charge_paused;
                2: v = charge_stopped;
                3: v = trickle_select;
                default: v = timer_reload;
            endcase
            if (v === want) break;
        end
        chk({15'h0, v}, {15'h0, want});
    endtask : wait_sig

    // cycles until the applied current code next moves
    task wait_change(output int cnt);
        logic [3:0] p;
        p   = fast_current;
        cnt = 0;
        do begin
            @(posedge clk_sys);
            #1;
            cnt++;
        end while (fast_current === p && cnt < 3000);
    endtask : wait_change

    // verdict and end of run
    task results;
        if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results

    // applied current never above the programmed limit while charging fast
    always @(negedge clk_sys) begin
        if (rst_b === 1'b1 && fast_active === 1'b1) chk({15'h0, fast_current > lim}, 16'h0);
    end

    // hang guard, well beyond the expected run length
    initial begin
        #(25 * 40000);
        error_cnt++;
        results();
    end

    initial begin
        {reg_wr, reg_rd, key_unlocked, reg_addr, reg_wdata} = '0;
        {set_active, set_wall, set_usb_hi} = 3'b110;
        batt_mv = 13'd3000;
        temp_c  = 8'd25;
        usb_cap = 4'hf;
        lim     = ISEL_RST;
        rst_b   = 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        // register reset values and an unmapped place
        chk({15'h0, trickle_select}, 16'h1);
        rd(ADR_CHG_CTRL_ONE, 16'h0000);
        rd(ADR_CHG_CTRL_TWO, 16'h1006);
        rd(ADR_CHG_CTRL_THR, 16'h0000);
        rd(8'h33, 16'h0000);
        // battery too low: no ready event, enable refused
        @(posedge clk_sys) key_unlocked <= 1'b1;
        wr(ADR_CHG_CTRL_ONE, 16'h0020);
        rd(ADR_CHG_CTRL_ONE, 16'h0000);
        rd(ADR_INT_STAT_ONE, 16'h0000);
        chk({15'h0, fast_active}, 16'h0);
        // battery good: event set once, cleared by read
        batt_mv <= 13'd3600;
        repeat (5) @(posedge clk_sys);
        rd(ADR_INT_STAT_ONE, 16'h0200);
        rd(ADR_INT_STAT_ONE, 16'h0000);
        // locked key blocks the enable write
        @(posedge clk_sys) key_unlocked <= 1'b0;
        wr(ADR_CHG_CTRL_ONE, 16'h0020);
        rd(ADR_CHG_CTRL_ONE, 16'h0000);
        @(posedge clk_sys) key_unlocked <= 1'b1;
        wr(ADR_CHG_CTRL_TWO, 16'h0008);
        lim = 4'h8;
        rd(ADR_CHG_CTRL_TWO, 16'h1008);
        // enable with throttling
        wr(ADR_CHG_CTRL_ONE, 16'h0030);
        #1 chk({15'h0, timer_reload}, 16'h1);
        wait_sig(0, 1'b1);
        rd(ADR_CHG_CTRL_TWO, 16'h2008);
        chk({12'h0, fast_current}, 16'h0008);
        chk({15'h0, trickle_select}, 16'h0);
        chk({15'h0, eoc_suppress}, 16'h1);
        // usb rail: throttle down and up, timing each step code
        @(posedge clk_sys);
        set_wall   <= 1'b0;
        set_usb_hi <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            wr(ADR_CHG_CTRL_THR, 16'(k << 5));
            rd(ADR_CHG_CTRL_THR, 16'(k << 5));
            usb_cap <= k[0] ? 4'hf : 4'h0;
            wait_change(n);
            wait_change(n);
            chk({15'h0, n >= step_exp[k] - 1 && n <= step_exp[k] + 1}, 16'h1);
            chk({12'h0, fast_current}, k[0] ? 16'h8 : 16'h6);
        end
        chk({15'h0, charge_stopped}, 16'h0);
        // no throttling: usb limit ends charging
        wr(ADR_CHG_CTRL_ONE, 16'h0020);
        usb_cap <= 4'h3;
        wait_sig(2, 1'b1);
        chk({15'h0, eoc_suppress}, 16'h0);
        chk({15'h0, fast_active}, 16'h0);
        rd(ADR_CHG_CTRL_TWO, 16'h0008);
        wr(ADR_CHG_CTRL_ONE, 16'h0000);
        set_wall   <= 1'b1;
        set_usb_hi <= 1'b0;
        usb_cap    <= 4'hf;
        repeat (4) @(posedge clk_sys);
        rd(ADR_CHG_CTRL_TWO, 16'h1008);
        // over-temperature pause holds its least length
        wr(ADR_CHG_CTRL_ONE, 16'h0020);
        wait_sig(0, 1'b1);
        @(posedge clk_sys) temp_c <= 8'd120;
        wait_sig(1, 1'b1);
        chk({15'h0, fast_active}, 16'h0);
        @(posedge clk_sys) temp_c <= 8'd25;
        repeat (30) @(posedge clk_sys);
        chk({15'h0, charge_paused}, 16'h1);
        wait_sig(1, 1'b0);
        wait_sig(0, 1'b1);
        // each lost condition falls back to trickle; no return on its own
        for (int c = 0; c < 3; c++) begin
            wr(ADR_CHG_CTRL_ONE, 16'h0020);
            wait_sig(0, 1'b1);
            @(posedge clk_sys);
            case (c)
                0: set_active <= 1'b0;
                1: set_wall <= 1'b0;
                default: batt_mv <= 13'd2800;
            endcase
            wait_sig(3, 1'b1);
            chk({12'h0, fast_current}, 16'h0);
            rd(ADR_CHG_CTRL_ONE, 16'h0000);
            @(posedge clk_sys);
            set_active <= 1'b1;
            set_wall   <= 1'b1;
            batt_mv    <= 13'd3600;
            repeat (10) @(posedge clk_sys);
            chk({15'h0, fast_active}, 16'h0);
        end
        results();
    end
endmodule : fcc_ctrl_tb
